// *** inc/rxpaf_pkg.sv ***
// Package: register map, field layout and reset values of the packet filter
package rxpaf_pkg;
  // Register indices; the byte address is the low byte of the index times four
  localparam logic [7:0]  IDX_CTRL_MASK0   = 8'h42;
  localparam logic [7:0]  IDX_CTRL_REF0    = 8'h46;
  localparam logic [7:0]  IDX_SRC_MASK     = 8'h4A;
  localparam logic [7:0]  IDX_SRC_ADDR     = 8'h4B;
  localparam logic [7:0]  IDX_BCAST_ADDR   = 8'h4C;
  localparam logic [7:0]  IDX_GROUP_ADDR   = 8'h4D;
  localparam logic [7:0]  IDX_OWN_ADDR     = 8'h4E;
  localparam logic [7:0]  IDX_FILT_OPT     = 8'h4F;
  localparam logic [7:0]  IDX_TMO_MASK     = 8'h50;
  localparam logic [7:0]  IDX_STATUS       = 8'h51;
  localparam logic [7:0]  CTRL_BYTES       = 8'h04;
  localparam int          OPT_TMO_OR       = 6;
  localparam int          OPT_CTRL_EN      = 5;
  localparam int          OPT_SRC_EN       = 4;
  localparam int          OPT_OWN_EN       = 3;
  localparam int          OPT_GROUP_EN     = 2;
  localparam int          OPT_BCAST_EN     = 1;
  localparam int          OPT_CRC_DROP     = 0;
  localparam int          TMO_CS_INCL      = 2;
  localparam int          TMO_SQ_INCL      = 1;
  localparam int          TMO_PQ_INCL      = 0;
  localparam logic [7:0]  OPT_RESET        = 8'h70;
  localparam logic [7:0]  OPT_RW_MASK      = 8'h7F;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  typedef enum logic [1:0]
  {
    RXPAF_IDLE = 2'b00,
    RXPAF_RESP = 2'b01
  } rxpaf_bus_state_t;
endpackage

// *** inc/rxpaf_match_if.sv ***
// Interface: one masked byte comparison
`timescale 1ns/1ps
`default_nettype none
interface rxpaf_match_if;
  logic [7:0] value;
  logic [7:0] ref_val;
  logic [7:0] mask;
  logic       hit;
  modport cmp (input value, input ref_val, input mask, output hit);
  modport user (output value, output ref_val, output mask, input hit);
endinterface
`default_nettype wire

// *** logic/rxpaf_byte_match.sv ***
// Masked byte compare: only bits with a one in the mask are checked
`timescale 1ns/1ps
`default_nettype none
module rxpaf_byte_match
(
  rxpaf_match_if.cmp m
);
  assign m.hit = ((m.value ^ m.ref_val) & m.mask) == 8'h00;
endmodule
`default_nettype wire

// *** logic/rxpaf_top.sv ***
// Receive packet address filter with AXI4-Lite register slave
// Contract
// - Select bit one ORs masked timeout indicators
// - Inclusion bits gate each indicator into timeout
// - Control filtering needs masked control byte match
// - Source filtering needs masked sender match
// - Own address enable accepts matching destination
// - Checksum drop discards packets failing check
// - Group enable accepts group address destination
// - Broadcast enable accepts broadcast destination
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rxpaf_top
  import rxpaf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pkt_valid,
  input  wire logic [31:0] pkt_ctrl,
  input  wire logic [7:0]  pkt_src,
  input  wire logic [7:0]  pkt_dest,
  input  wire logic        pkt_crc_ok,
  input  wire logic        carrier_sense,
  input  wire logic        sync_quality_ind,
  input  wire logic        preamble_quality_ind,
  output var  logic        pkt_done,
  output var  logic        pkt_accept,
  output var  logic        rx_timeout_stop
);
  import rxpaf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl_mask_reg [CTRL_BYTES];
  logic [7:0]  ctrl_ref_byte_reg [CTRL_BYTES];
  logic [7:0]  src_mask_reg;
  logic [7:0]  src_addr_reg;
  logic [7:0]  bcast_addr_reg;
  logic [7:0]  group_addr_reg;
  logic [7:0]  own_addr_reg;
  logic [7:0]  rx_filter_options_reg;
  logic [2:0]  tmo_incl_reg;
  logic [7:0]  accept_cnt_reg;
  logic [7:0]  reject_cnt_reg;
  logic [CTRL_BYTES-1:0] ctrl_hit;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  rxpaf_bus_state_t rd_state_reg;
  logic        wr_go;
  logic        wr_hit;
  logic        src_hit;
  logic        dest_ok;
  logic        pkt_ok;
  logic [2:0]  ind_vec;
  logic        tmo_or;
  logic        tmo_and;
  logic [31:0] rd_mux;
  logic        rd_ok;

  ////////////////////////////////////////////////////////////////////////
  // Control bytes: byte 3 of the packet is compared with reference 0
  for (genvar i = 0; i < CTRL_BYTES; i++)
  begin : g_ctrl
    rxpaf_match_if mi ();
    assign mi.value   = pkt_ctrl[8*(CTRL_BYTES-1-i) +: 8];
    assign mi.ref_val = ctrl_ref_byte_reg[i];
    assign mi.mask    = ctrl_mask_reg[i];
    assign ctrl_hit[i] = mi.hit;
    rxpaf_byte_match u_cmp (.m(mi));
  end

  rxpaf_match_if smi ();
  assign smi.value   = pkt_src;
  assign smi.ref_val = src_addr_reg;
  assign smi.mask    = src_mask_reg;
  assign src_hit     = smi.hit;
  rxpaf_byte_match u_src (.m(smi));

  ////////////////////////////////////////////////////////////////////////
  // Destination checks: any enabled match accepts; none enabled passes all
  always_comb
  begin
    logic any_en;
    any_en = rx_filter_options_reg[OPT_OWN_EN] | rx_filter_options_reg[OPT_GROUP_EN]
           | rx_filter_options_reg[OPT_BCAST_EN];
    dest_ok = !any_en
      | (rx_filter_options_reg[OPT_OWN_EN] && pkt_dest == own_addr_reg)
      | (rx_filter_options_reg[OPT_GROUP_EN] && pkt_dest == group_addr_reg)
      | (rx_filter_options_reg[OPT_BCAST_EN] && pkt_dest == bcast_addr_reg);
  end

  assign pkt_ok = dest_ok
    && (!rx_filter_options_reg[OPT_CTRL_EN] || &ctrl_hit)
    && (!rx_filter_options_reg[OPT_SRC_EN] || src_hit)
    && (!rx_filter_options_reg[OPT_CRC_DROP] || pkt_crc_ok);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pkt_done   <= 1'b0;
      pkt_accept <= 1'b0;
    end
    else
    begin
      pkt_done   <= pkt_valid;
      pkt_accept <= pkt_valid && pkt_ok;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accept_cnt_reg <= 8'h00;
      reject_cnt_reg <= 8'h00;
    end
    else if (pkt_valid)
    begin
      if (pkt_ok)
        accept_cnt_reg <= accept_cnt_reg + 8'h01;
      else
        reject_cnt_reg <= reject_cnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Excluded indicators are neutral: zero for OR, one for AND
  assign ind_vec = {carrier_sense, sync_quality_ind, preamble_quality_ind};
  assign tmo_or  = |(ind_vec & tmo_incl_reg);
  assign tmo_and = (tmo_incl_reg != 3'h0) && &(ind_vec | ~tmo_incl_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_timeout_stop <= 1'b0;
    else
      rx_timeout_stop <= rx_filter_options_reg[OPT_TMO_OR] ? tmo_or : tmo_and;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched independently, then one response
  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  end

  // Only byte lane 0 carries data; other lanes are ignored
  always_comb
  begin
    logic [5:0] idx;
    idx    = aw_addr_reg[7:2];
    wr_hit = (aw_addr_reg[1:0] == 2'b00)
          && ((idx >= IDX_CTRL_MASK0[5:0] && idx <= IDX_TMO_MASK[5:0]) || idx == IDX_STATUS[5:0]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int k = 0; k < CTRL_BYTES; k++)
      begin
        ctrl_mask_reg[k]     <= 8'h00;
        ctrl_ref_byte_reg[k] <= 8'h00;
      end
      src_mask_reg          <= 8'h00;
      src_addr_reg          <= 8'h00;
      bcast_addr_reg        <= 8'h00;
      group_addr_reg        <= 8'h00;
      own_addr_reg          <= 8'h00;
      rx_filter_options_reg <= OPT_RESET;
      tmo_incl_reg          <= 3'h0;
    end
    else if (wr_go && w_strb_reg[0] && aw_addr_reg[1:0] == 2'b00)
    begin
      for (int k = 0; k < CTRL_BYTES; k++)
      begin
        if (aw_addr_reg[7:2] == IDX_CTRL_MASK0[5:0] + k[5:0])
          ctrl_mask_reg[k] <= w_data_reg[7:0];
        if (aw_addr_reg[7:2] == IDX_CTRL_REF0[5:0] + k[5:0])
          ctrl_ref_byte_reg[k] <= w_data_reg[7:0];
      end
      unique case (aw_addr_reg[7:2])
        IDX_SRC_MASK[5:0]:   src_mask_reg          <= w_data_reg[7:0];
        IDX_SRC_ADDR[5:0]:   src_addr_reg          <= w_data_reg[7:0];
        IDX_BCAST_ADDR[5:0]: bcast_addr_reg        <= w_data_reg[7:0];
        IDX_GROUP_ADDR[5:0]: group_addr_reg        <= w_data_reg[7:0];
        IDX_OWN_ADDR[5:0]:   own_addr_reg          <= w_data_reg[7:0];
        IDX_FILT_OPT[5:0]:   rx_filter_options_reg <= w_data_reg[7:0] & OPT_RW_MASK;
        IDX_TMO_MASK[5:0]:   tmo_incl_reg          <= w_data_reg[2:0];
        default:             ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered the cycle after it is taken
  always_comb
  begin
    logic [5:0] idx;
    idx    = s_axi_araddr[7:2];
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (idx >= IDX_CTRL_MASK0[5:0] && idx < IDX_CTRL_REF0[5:0])
      rd_mux[7:0] = ctrl_mask_reg[2'(idx - IDX_CTRL_MASK0[5:0])];
    else if (idx >= IDX_CTRL_REF0[5:0] && idx < IDX_SRC_MASK[5:0])
      rd_mux[7:0] = ctrl_ref_byte_reg[2'(idx - IDX_CTRL_REF0[5:0])];
    else if (idx == IDX_SRC_MASK[5:0])
      rd_mux[7:0] = src_mask_reg;
    else if (idx == IDX_SRC_ADDR[5:0])
      rd_mux[7:0] = src_addr_reg;
    else if (idx == IDX_BCAST_ADDR[5:0])
      rd_mux[7:0] = bcast_addr_reg;
    else if (idx == IDX_GROUP_ADDR[5:0])
      rd_mux[7:0] = group_addr_reg;
    else if (idx == IDX_OWN_ADDR[5:0])
      rd_mux[7:0] = own_addr_reg;
    else if (idx == IDX_FILT_OPT[5:0])
      rd_mux[7:0] = rx_filter_options_reg;
    else if (idx == IDX_TMO_MASK[5:0])
      rd_mux[2:0] = tmo_incl_reg;
    else if (idx == IDX_STATUS[5:0])
      rd_mux = {15'h0000, rx_timeout_stop, reject_cnt_reg, accept_cnt_reg};
    else
      rd_ok = 1'b0;
    if (s_axi_araddr[1:0] != 2'b00)
      rd_ok = 1'b0;
  end

  assign s_axi_arready = (rd_state_reg == RXPAF_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_reg <= RXPAF_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else
    begin
      unique case (rd_state_reg)
        RXPAF_IDLE:
          if (s_axi_arvalid)
          begin
            rd_state_reg <= RXPAF_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
          end
        RXPAF_RESP:
          if (s_axi_rready)
          begin
            rd_state_reg <= RXPAF_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        default:
          rd_state_reg <= RXPAF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference compares rebuilt here so a broken filter path is caught
  a_crc_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_valid && rx_filter_options_reg[OPT_CRC_DROP] && !pkt_crc_ok |=> !pkt_accept)
    else $error("packet with bad checksum was kept");
  a_ctrl_reject: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_valid && rx_filter_options_reg[OPT_CTRL_EN]
    && (((pkt_ctrl[31:24] ^ ctrl_ref_byte_reg[0]) & ctrl_mask_reg[0]) != 8'h00) |=> !pkt_accept)
    else $error("packet with wrong control byte was kept");
  a_src_reject: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_valid && rx_filter_options_reg[OPT_SRC_EN]
    && (((pkt_src ^ src_addr_reg) & src_mask_reg) != 8'h00) |=> !pkt_accept)
    else $error("packet from wrong sender was kept");
  a_own_accept: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_valid && rx_filter_options_reg[OPT_OWN_EN] && pkt_dest == own_addr_reg
    && rx_filter_options_reg[OPT_CRC_DROP:OPT_CRC_DROP] == 1'b0
    && !rx_filter_options_reg[OPT_CTRL_EN] && !rx_filter_options_reg[OPT_SRC_EN] |=> pkt_accept)
    else $error("packet for own address was dropped");
  a_tmo_or_cs: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_filter_options_reg[OPT_TMO_OR] && tmo_incl_reg[TMO_CS_INCL] && carrier_sense
    |=> rx_timeout_stop)
    else $error("included carrier sense did not stop timeout");
  a_tmo_and_sq: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_filter_options_reg[OPT_TMO_OR] && tmo_incl_reg[TMO_SQ_INCL] && !sync_quality_ind
    |=> !rx_timeout_stop)
    else $error("timeout stopped without all indicators");
  a_accept_done: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_accept |-> pkt_done)
    else $error("accept pulse without done pulse");
  c_pkt_kept: cover property (@(posedge aclk) disable iff (!aresetn) pkt_accept);
  c_pkt_dropped: cover property (@(posedge aclk) disable iff (!aresetn) pkt_done && !pkt_accept);
  c_tmo_stop: cover property (@(posedge aclk) disable iff (!aresetn) rx_timeout_stop);
endmodule
`default_nettype wire

// *** verif/rxpaf_radio_node.sv ***
// Partner model: remote radio node presenting packets and link indicators
`timescale 1ns/1ps
`default_nettype none
module rxpaf_radio_node
(
  input  wire logic        aclk,
  output var  logic        pkt_valid,
  output var  logic [31:0] pkt_ctrl,
  output var  logic [7:0]  pkt_src,
  output var  logic [7:0]  pkt_dest,
  output var  logic        pkt_crc_ok,
  output var  logic        carrier_sense,
  output var  logic        sync_quality_ind,
  output var  logic        preamble_quality_ind
);
  initial
  begin
    pkt_valid = 1'b0;
    pkt_ctrl = 32'h0;
    pkt_src = 8'h0;
    pkt_dest = 8'h0;
    pkt_crc_ok = 1'b0;
    {carrier_sense, sync_quality_ind, preamble_quality_ind} = 3'h0;
  end
  ////////////////////////////////////////////////////////////////
  // Fields scrambled outside the strobe so stale values never match
  task automatic send(input logic [31:0] c, input logic [7:0] s,
                      input logic [7:0] d, input logic ok);
    @(posedge aclk);
    pkt_ctrl <= c;
    pkt_src <= s;
    pkt_dest <= d;
    pkt_crc_ok <= ok;
    pkt_valid <= 1'b1;
    @(posedge aclk);
    pkt_valid <= 1'b0;
    pkt_ctrl <= ~c;
    pkt_src <= ~s;
    pkt_dest <= ~d;
    pkt_crc_ok <= ~ok;
  endtask
  task automatic set_ind(input logic [2:0] v);
    @(posedge aclk);
    {carrier_sense, sync_quality_ind, preamble_quality_ind} <= v;
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Testbench: register access over AXI4-Lite and packet filter checks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rxpaf_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, pkt_valid, pkt_crc_ok, carrier_sense, sync_quality_ind;
  logic preamble_quality_ind, pkt_done, pkt_accept, rx_timeout_stop;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pkt_src, pkt_dest;
  logic [31:0] s_axi_wdata, s_axi_rdata, pkt_ctrl, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb;
  int          n_mismatch, n_tests;
  rxpaf_top rxpaf_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pkt_valid, .pkt_ctrl, .pkt_src, .pkt_dest, .pkt_crc_ok, .carrier_sense,
    .sync_quality_ind, .preamble_quality_ind, .pkt_done, .pkt_accept,
    .rx_timeout_stop);
  rxpaf_radio_node rxpaf_radio_node_inst (.aclk, .pkt_valid, .pkt_ctrl,
    .pkt_src, .pkt_dest, .pkt_crc_ok, .carrier_sense, .sync_quality_ind,
    .preamble_quality_ind);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  // 8-bit bus keeps only the low byte of index times four
  function automatic logic [7:0] a4(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid !== 1'b0 && !ta || s_axi_wvalid !== 1'b0 && !tw);
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(negedge aclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pk(input logic [31:0] c, input logic [7:0] s, input logic [7:0] d,
                    input logic ok, input logic exp);
    rxpaf_radio_node_inst.send(c, s, d, ok);
    #1;
    chk("pkt_done", pkt_done, 1);
    chk("pkt_accept", pkt_accept, exp);
  endtask
  task automatic tm(input logic [2:0] v, input logic exp);
    rxpaf_radio_node_inst.set_ind(v);
    @(posedge aclk);
    #1;
    chk("rx_timeout_stop", rx_timeout_stop, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    logic [7:0] dop [6] = '{8'h08, 8'h08, 8'h04, 8'h04, 8'h02, 8'h02};
    logic [7:0] dad [6] = '{8'h11, 8'h22, 8'h22, 8'h33, 8'h33, 8'h11};
    logic       dex [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(a4(IDX_FILT_OPT));
    chk("opt reset", rd, 32'h70);
    wr(a4(IDX_FILT_OPT), 32'hFFFFFFFF);
    chk("opt bresp", rsp, RESP_OKAY);
    rdr(a4(IDX_FILT_OPT));
    chk("opt rw", rd, 32'h7F);
    rdr(8'hF0);
    chk("unmapped rresp", {rd, rsp}, {32'h0, RESP_SLVERR});
    wr(8'hF0, 32'h1);
    chk("unmapped bresp", rsp, RESP_SLVERR);
    $display("test registers done");
    wr(a4(IDX_FILT_OPT), 32'h20);
    wr(a4(IDX_CTRL_MASK0), 32'hFF);
    wr(a4(IDX_CTRL_REF0), 32'hA5);
    pk(32'hA50000FF, 8'h5A, 8'h00, 1'b1, 1'b1);
    pk(32'hA4000000, 8'h00, 8'h00, 1'b1, 1'b0);
    wr(a4(IDX_FILT_OPT), 32'h10);
    wr(a4(IDX_SRC_MASK), 32'h0F);
    wr(a4(IDX_SRC_ADDR), 32'h03);
    pk(32'h0, 8'hF3, 8'h00, 1'b1, 1'b1);
    pk(32'h0, 8'h04, 8'h00, 1'b1, 1'b0);
    $display("test control and source done");
    wr(a4(IDX_OWN_ADDR), 32'h11);
    wr(a4(IDX_GROUP_ADDR), 32'h22);
    wr(a4(IDX_BCAST_ADDR), 32'h33);
    for (int i = 0; i < 6; i++)
    begin
      wr(a4(IDX_FILT_OPT), {24'h0, dop[i]});
      pk(32'h0, 8'h00, dad[i], 1'b1, dex[i]);
    end
    wr(a4(IDX_FILT_OPT), 32'h01);
    pk(32'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    pk(32'h0, 8'h00, 8'h00, 1'b1, 1'b1);
    wr(a4(IDX_FILT_OPT), 32'h00);
    pk(32'h0, 8'h00, 8'h00, 1'b0, 1'b1);
    $display("test destination and checksum done");
    wr(a4(IDX_TMO_MASK), 32'h4);
    wr(a4(IDX_FILT_OPT), 32'h40);
    tm(3'b100, 1'b1);
    tm(3'b011, 1'b0);
    wr(a4(IDX_FILT_OPT), 32'h00);
    wr(a4(IDX_TMO_MASK), 32'h3);
    tm(3'b010, 1'b0);
    tm(3'b011, 1'b1);
    rdr(a4(IDX_STATUS));
    chk("status", rd, 32'h0001_0607);
    $display("test timeout done");
    report_and_stop();
  end
endmodule
`default_nettype wire
